// ===== include/srd_pkg.sv
`default_nettype none
package srd_pkg;
    // ****************************************
    // Decoded operation classes
    // ****************************************
    typedef enum logic [4:0] {
        OP_NONE,
        OP_ROTATE_LEFT,
        OP_ROTATE_RIGHT,
        OP_SHIFT_LEFT_ARITH,
        OP_SHIFT_RIGHT_ARITH,
        OP_SUBTRACT_WITH_BORROW,
        OP_RESTORE_SEG_AND_DESC,
        OP_RESTORE_LOCAL_TABLE_REG,
        OP_RESTORE_TASK_REG_AND_DESC,
        OP_LEAVE_SYSTEM_MGMT_MODE,
        OP_FLAGS_FROM_ACC_HIGH,
        OP_SET_BYTE_IF_BELOW,
        OP_SET_BYTE_IF_BELOW_OR_EQUAL,
        OP_SET_BYTE_IF_EQUAL,
        OP_SET_BYTE_IF_LESS
    } srd_op_t;

    // ****************************************
    // Shift count source
    // ****************************************
    typedef enum logic [1:0] {
        CNT_NONE,
        CNT_ONE,
        CNT_COUNT_REGISTER_LOW,
        CNT_IMMEDIATE
    } srd_cnt_t;

    // ****************************************
    // Opcode patterns
    // ****************************************
    localparam logic [7:0] OPC_ESCAPE = 8'h0f;
    localparam logic [5:0] OPC_SHIFT_GRP_D = 6'h34;
    localparam logic [6:0] OPC_SHIFT_GRP_C = 7'h60;
    localparam logic [5:0] OPC_IMM_GRP_8 = 6'h20;
    localparam logic [5:0] OPC_SUB_BORROW_RM = 6'h06;
    localparam logic [6:0] OPC_SUB_BORROW_ACC = 7'h0e;
    localparam logic [7:0] OPC_FLAGS_FROM_ACC_HIGH = 8'h9e;
    localparam logic [7:0] OPC2_RESTORE_SEG = 8'h79;
    localparam logic [7:0] OPC2_RESTORE_LOCAL = 8'h7b;
    localparam logic [7:0] OPC2_RESTORE_TASK = 8'h7d;
    localparam logic [7:0] OPC2_LEAVE_MGMT = 8'haa;
    localparam logic [7:0] OPC2_SET_BELOW = 8'h92;
    localparam logic [7:0] OPC2_SET_BELOW_EQ = 8'h96;
    localparam logic [7:0] OPC2_SET_EQUAL = 8'h94;
    localparam logic [7:0] OPC2_SET_LESS = 8'h9c;
    localparam logic [3:0] COND_BELOW = 4'h2;
    localparam logic [3:0] COND_BELOW_EQ = 4'h6;
    localparam logic [3:0] COND_EQUAL = 4'h4;
    localparam logic [3:0] COND_LESS = 4'hc;

    // ****************************************
    // Addressing-byte reg field codes
    // ****************************************
    localparam logic [2:0] REG_ROTATE_LEFT = 3'h0;
    localparam logic [2:0] REG_ROTATE_RIGHT = 3'h1;
    localparam logic [2:0] REG_SUB_BORROW = 3'h3;
    localparam logic [2:0] REG_SHIFT_LEFT_ARITH = 3'h4;
    localparam logic [2:0] REG_SHIFT_RIGHT_ARITH = 3'h7;
    localparam logic [2:0] REG_ZERO = 3'h0;
    localparam logic [2:0] REG_SEG_LAST = 3'h5;

    // ****************************************
    // Issue clock counts
    // ****************************************
    localparam logic [5:0] CYC_ONE = 6'h01;
    localparam logic [5:0] CYC_COUNT_REG = 6'h02;
    localparam logic [5:0] CYC_RESTORE = 6'h06;
    localparam logic [5:0] CYC_LEAVE_MGMT = 6'h28;

    // ****************************************
    // Immediate sizes in bytes
    // ****************************************
    localparam logic [2:0] IMM_NONE = 3'h0;
    localparam logic [2:0] IMM_BYTE = 3'h1;
    localparam logic [2:0] IMM_WORD = 3'h2;
    localparam logic [2:0] IMM_DWORD = 3'h4;

    // ****************************************
    // Flag positions and masks
    // ****************************************
    localparam int FLG_CARRY = 0;
    localparam int FLG_PARITY = 1;
    localparam int FLG_AUX = 2;
    localparam int FLG_ZERO = 3;
    localparam int FLG_SIGN = 4;
    localparam int FLG_OVERFLOW = 8;
    localparam logic [8:0] MASK_NONE = 9'h000;
    localparam logic [8:0] MASK_ALL = 9'h1ff;
    localparam logic [8:0] MASK_LOW_FIVE = 9'h01f;
    localparam logic [8:0] MASK_ARITH_SIX = 9'h11f;
    localparam logic [8:0] MASK_SHIFT_ONE_WR = 9'h11b;
    localparam logic [8:0] MASK_SHIFT_ONE_UND = 9'h004;
    localparam logic [8:0] MASK_SHIFT_N_WR = 9'h01b;
    localparam logic [8:0] MASK_SHIFT_N_UND = 9'h104;
    localparam logic [8:0] MASK_ROT_ONE_WR = 9'h101;
    localparam logic [8:0] MASK_ROT_N_WR = 9'h001;
    localparam logic [8:0] MASK_ROT_N_UND = 9'h100;
    localparam logic [7:0] SET_TRUE = 8'h01;
    localparam logic [7:0] SET_FALSE = 8'h00;
endpackage
`default_nettype wire

// ===== hw/srd_imm_size.sv
`default_nettype none
module srd_imm_size (
    input wire logic [7:0] opc0,
    input wire logic opsize32,
    output logic [2:0] imm_bytes
);
    logic [2:0] full_size;

    // ****************************************
    // Immediate length by opcode
    // ****************************************
    always_comb begin
        full_size = opsize32 ? srd_pkg::IMM_DWORD : srd_pkg::IMM_WORD;
        imm_bytes = srd_pkg::IMM_NONE;
        if (opc0[7:1] == srd_pkg::OPC_SHIFT_GRP_C) begin
            imm_bytes = srd_pkg::IMM_BYTE;
        end else if (opc0[7:2] == srd_pkg::OPC_IMM_GRP_8) begin
            if (opc0[1] || !opc0[0]) begin
                imm_bytes = srd_pkg::IMM_BYTE;
            end else begin
                imm_bytes = full_size;
            end
        end else if (opc0[7:1] == srd_pkg::OPC_SUB_BORROW_ACC) begin
            imm_bytes = opc0[0] ? full_size : srd_pkg::IMM_BYTE;
        end
    end
endmodule // srd_imm_size
`default_nettype wire

// ===== hw/srd_cond.sv
`default_nettype none
module srd_cond (
    input wire logic [3:0] cond_code,
    input wire logic [8:0] flags,
    output logic known,
    output logic [7:0] set_value
);
    logic hit;

    // ****************************************
    // Condition evaluation
    // ****************************************
    always_comb begin
        hit = 1'b0;
        known = 1'b1;
        case (cond_code)
            srd_pkg::COND_BELOW: hit = flags[srd_pkg::FLG_CARRY];
            srd_pkg::COND_BELOW_EQ: begin
                hit = flags[srd_pkg::FLG_CARRY] | flags[srd_pkg::FLG_ZERO];
            end
            srd_pkg::COND_EQUAL: hit = flags[srd_pkg::FLG_ZERO];
            srd_pkg::COND_LESS: begin
                hit = flags[srd_pkg::FLG_SIGN] ^ flags[srd_pkg::FLG_OVERFLOW];
            end
            default: known = 1'b0;
        endcase
        set_value = hit ? srd_pkg::SET_TRUE : srd_pkg::SET_FALSE;
    end
endmodule // srd_cond
`default_nettype wire

// ===== hw/srd_decoder.sv
`default_nettype none
module srd_decoder (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic INSN_VALID,
    input wire logic [7:0] INSN_OPC0,
    input wire logic [7:0] INSN_OPC1,
    input wire logic [7:0] INSN_MODRM,
    input wire logic OPSIZE32,
    input wire logic [8:0] STATUS_FLAGS,
    output logic INSN_READY,
    output logic ISSUE_VALID,
    output srd_pkg::srd_op_t ISSUE_OP,
    output srd_pkg::srd_cnt_t ISSUE_COUNT_SRC,
    output logic ISSUE_WIDE,
    output logic [5:0] ISSUE_CYCLES,
    output logic [2:0] ISSUE_IMM_BYTES,
    output logic [2:0] ISSUE_SEG_SEL,
    output logic [8:0] FLAG_WRITE,
    output logic [8:0] FLAG_UNDEF,
    output logic [7:0] SET_BYTE_DATA,
    output logic ISSUE_ILLEGAL
);
    typedef struct packed {
        logic ready;
        logic [5:0] busy_cnt;
        logic valid;
        srd_pkg::srd_op_t op;
        srd_pkg::srd_cnt_t cnt_src;
        logic wide;
        logic [5:0] cycles;
        logic [2:0] imm_bytes;
        logic [2:0] seg_sel;
        logic [8:0] flag_wr;
        logic [8:0] flag_und;
        logic [7:0] set_data;
        logic illegal;
    } srd_state_t;

    srd_state_t st_r;
    srd_state_t st_nxt;
    logic [2:0] imm_bytes;
    logic cond_known;
    logic [7:0] cond_value;
    logic accept;
    logic [2:0] reg_fld;

    assign reg_fld = INSN_MODRM[5:3];
    assign accept = INSN_VALID && st_r.ready;

    // ****************************************
    // Helpers
    // ****************************************
    srd_imm_size u_imm (
        .opc0(INSN_OPC0),
        .opsize32(OPSIZE32),
        .imm_bytes(imm_bytes)
    );

    srd_cond u_cond (
        .cond_code(INSN_OPC1[3:0]),
        .flags(STATUS_FLAGS),
        .known(cond_known),
        .set_value(cond_value)
    );

    // ****************************************
    // Decode and issue timing
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        if (st_r.busy_cnt != 6'h00) begin
            st_nxt.busy_cnt = st_r.busy_cnt - 6'h01;
        end
        if (accept) begin
            st_nxt.valid = 1'b1;
            st_nxt.op = srd_pkg::OP_NONE;
            st_nxt.cnt_src = srd_pkg::CNT_NONE;
            st_nxt.wide = INSN_OPC0[0];
            st_nxt.cycles = srd_pkg::CYC_ONE;
            st_nxt.imm_bytes = imm_bytes;
            st_nxt.seg_sel = 3'h0;
            st_nxt.flag_wr = srd_pkg::MASK_NONE;
            st_nxt.flag_und = srd_pkg::MASK_NONE;
            st_nxt.set_data = srd_pkg::SET_FALSE;
            st_nxt.illegal = 1'b1;
            if (INSN_OPC0[7:2] == srd_pkg::OPC_SHIFT_GRP_D
                    || INSN_OPC0[7:1] == srd_pkg::OPC_SHIFT_GRP_C) begin
                st_nxt.illegal = 1'b0;
                if (INSN_OPC0[7:1] == srd_pkg::OPC_SHIFT_GRP_C) begin
                    st_nxt.cnt_src = srd_pkg::CNT_IMMEDIATE;
                end else if (INSN_OPC0[1]) begin
                    st_nxt.cnt_src = srd_pkg::CNT_COUNT_REGISTER_LOW;
                    st_nxt.cycles = srd_pkg::CYC_COUNT_REG;
                end else begin
                    st_nxt.cnt_src = srd_pkg::CNT_ONE;
                end
                case (reg_fld)
                    srd_pkg::REG_ROTATE_LEFT, srd_pkg::REG_ROTATE_RIGHT: begin
                        st_nxt.op = (reg_fld == srd_pkg::REG_ROTATE_LEFT)
                            ? srd_pkg::OP_ROTATE_LEFT : srd_pkg::OP_ROTATE_RIGHT;
                        if (st_nxt.cnt_src == srd_pkg::CNT_ONE) begin
                            st_nxt.flag_wr = srd_pkg::MASK_ROT_ONE_WR;
                        end else begin
                            st_nxt.flag_wr = srd_pkg::MASK_ROT_N_WR;
                            st_nxt.flag_und = srd_pkg::MASK_ROT_N_UND;
                        end
                    end
                    srd_pkg::REG_SHIFT_LEFT_ARITH, srd_pkg::REG_SHIFT_RIGHT_ARITH: begin
                        st_nxt.op = (reg_fld == srd_pkg::REG_SHIFT_LEFT_ARITH)
                            ? srd_pkg::OP_SHIFT_LEFT_ARITH
                            : srd_pkg::OP_SHIFT_RIGHT_ARITH;
                        if (st_nxt.cnt_src == srd_pkg::CNT_ONE) begin
                            st_nxt.flag_wr = srd_pkg::MASK_SHIFT_ONE_WR;
                            st_nxt.flag_und = srd_pkg::MASK_SHIFT_ONE_UND;
                        end else begin
                            st_nxt.flag_wr = srd_pkg::MASK_SHIFT_N_WR;
                            st_nxt.flag_und = srd_pkg::MASK_SHIFT_N_UND;
                        end
                    end
                    default: begin
                        st_nxt.illegal = 1'b1;
                        st_nxt.cnt_src = srd_pkg::CNT_NONE;
                        st_nxt.cycles = srd_pkg::CYC_ONE;
                    end
                endcase
            end else if (INSN_OPC0[7:2] == srd_pkg::OPC_SUB_BORROW_RM
                    || INSN_OPC0[7:1] == srd_pkg::OPC_SUB_BORROW_ACC
                    || (INSN_OPC0[7:2] == srd_pkg::OPC_IMM_GRP_8
                        && reg_fld == srd_pkg::REG_SUB_BORROW)) begin
                st_nxt.illegal = 1'b0;
                st_nxt.op = srd_pkg::OP_SUBTRACT_WITH_BORROW;
                st_nxt.flag_wr = srd_pkg::MASK_ARITH_SIX;
            end else if (INSN_OPC0 == srd_pkg::OPC_FLAGS_FROM_ACC_HIGH) begin
                st_nxt.illegal = 1'b0;
                st_nxt.op = srd_pkg::OP_FLAGS_FROM_ACC_HIGH;
                st_nxt.flag_wr = srd_pkg::MASK_LOW_FIVE;
            end else if (INSN_OPC0 == srd_pkg::OPC_ESCAPE) begin
                st_nxt.wide = 1'b0;
                case (INSN_OPC1)
                    srd_pkg::OPC2_RESTORE_SEG: begin
                        if (reg_fld <= srd_pkg::REG_SEG_LAST) begin
                            st_nxt.illegal = 1'b0;
                            st_nxt.op = srd_pkg::OP_RESTORE_SEG_AND_DESC;
                            st_nxt.seg_sel = reg_fld;
                            st_nxt.cycles = srd_pkg::CYC_RESTORE;
                        end
                    end
                    srd_pkg::OPC2_RESTORE_LOCAL, srd_pkg::OPC2_RESTORE_TASK: begin
                        if (reg_fld == srd_pkg::REG_ZERO) begin
                            st_nxt.illegal = 1'b0;
                            st_nxt.op = (INSN_OPC1 == srd_pkg::OPC2_RESTORE_LOCAL)
                                ? srd_pkg::OP_RESTORE_LOCAL_TABLE_REG
                                : srd_pkg::OP_RESTORE_TASK_REG_AND_DESC;
                            st_nxt.cycles = srd_pkg::CYC_RESTORE;
                        end
                    end
                    srd_pkg::OPC2_LEAVE_MGMT: begin
                        st_nxt.illegal = 1'b0;
                        st_nxt.op = srd_pkg::OP_LEAVE_SYSTEM_MGMT_MODE;
                        st_nxt.cycles = srd_pkg::CYC_LEAVE_MGMT;
                        st_nxt.flag_wr = srd_pkg::MASK_ALL;
                    end
                    srd_pkg::OPC2_SET_BELOW, srd_pkg::OPC2_SET_BELOW_EQ,
                    srd_pkg::OPC2_SET_EQUAL, srd_pkg::OPC2_SET_LESS: begin
                        if (reg_fld == srd_pkg::REG_ZERO && cond_known) begin
                            st_nxt.illegal = 1'b0;
                            case (INSN_OPC1)
                                srd_pkg::OPC2_SET_BELOW:
                                    st_nxt.op = srd_pkg::OP_SET_BYTE_IF_BELOW;
                                srd_pkg::OPC2_SET_BELOW_EQ:
                                    st_nxt.op = srd_pkg::OP_SET_BYTE_IF_BELOW_OR_EQUAL;
                                srd_pkg::OPC2_SET_EQUAL:
                                    st_nxt.op = srd_pkg::OP_SET_BYTE_IF_EQUAL;
                                default:
                                    st_nxt.op = srd_pkg::OP_SET_BYTE_IF_LESS;
                            endcase
                            st_nxt.set_data = cond_value;
                        end
                    end
                    default: st_nxt.illegal = 1'b1;
                endcase
            end
            st_nxt.busy_cnt = st_nxt.cycles - 6'h01;
        end
        st_nxt.ready = (st_nxt.busy_cnt == 6'h00);
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            st_r <= '{ready: 1'b1, busy_cnt: 6'h00, valid: 1'b0,
                op: srd_pkg::OP_NONE, cnt_src: srd_pkg::CNT_NONE, wide: 1'b0,
                cycles: 6'h00, imm_bytes: 3'h0, seg_sel: 3'h0, flag_wr: 9'h000,
                flag_und: 9'h000, set_data: 8'h00, illegal: 1'b0};
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign INSN_READY = st_r.ready;
    assign ISSUE_VALID = st_r.valid;
    assign ISSUE_OP = st_r.op;
    assign ISSUE_COUNT_SRC = st_r.cnt_src;
    assign ISSUE_WIDE = st_r.wide;
    assign ISSUE_CYCLES = st_r.cycles;
    assign ISSUE_IMM_BYTES = st_r.imm_bytes;
    assign ISSUE_SEG_SEL = st_r.seg_sel;
    assign FLAG_WRITE = st_r.flag_wr;
    assign FLAG_UNDEF = st_r.flag_und;
    assign SET_BYTE_DATA = st_r.set_data;
    assign ISSUE_ILLEGAL = st_r.illegal;

    // ****************************************
    // Checks
    // ****************************************
    rotate_count_time_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        accept && INSN_OPC0[7:1] == 7'h69 && reg_fld == 3'h0
        |=> ISSUE_OP == srd_pkg::OP_ROTATE_LEFT && !INSN_READY ##1 INSN_READY)
        else $error("count-register rotate not two clocks");

    rotate_imm_time_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        accept && INSN_OPC0[7:1] == 7'h60 && reg_fld == 3'h1
        |=> ISSUE_OP == srd_pkg::OP_ROTATE_RIGHT && ISSUE_IMM_BYTES == 3'h1
            && ISSUE_COUNT_SRC == srd_pkg::CNT_IMMEDIATE && INSN_READY)
        else $error("immediate rotate decoded wrongly");

    restore_busy_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        ISSUE_VALID && ISSUE_CYCLES == 6'h06
        |-> !INSN_READY [*5] ##1 INSN_READY)
        else $error("restore not six clocks");

    leave_mgmt_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        accept && INSN_OPC0 == 8'h0f && INSN_OPC1 == 8'haa
        |=> FLAG_WRITE == 9'h1ff && ISSUE_CYCLES == 6'h28 && !INSN_READY
            ##38 !INSN_READY ##1 INSN_READY)
        else $error("management exit timing wrong");

    acc_high_flags_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        accept && INSN_OPC0 == 8'h9e
        |=> FLAG_WRITE == 9'h01f && ISSUE_CYCLES == 6'h01 && INSN_READY)
        else $error("flag load from accumulator wrong");

    shift_flags_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        ISSUE_VALID && ISSUE_OP == srd_pkg::OP_SHIFT_RIGHT_ARITH
        |-> FLAG_UNDEF[2] && FLAG_WRITE[8] == (ISSUE_COUNT_SRC == srd_pkg::CNT_ONE))
        else $error("arithmetic shift flag masks wrong");

    borrow_one_clock_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        ISSUE_VALID && ISSUE_OP == srd_pkg::OP_SUBTRACT_WITH_BORROW
        |-> INSN_READY && FLAG_WRITE == 9'h11f)
        else $error("borrow subtract not one clock");

    set_below_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        accept && INSN_OPC0 == 8'h0f && INSN_OPC1 == 8'h92 && reg_fld == 3'h0
        |=> SET_BYTE_DATA == {7'h00, $past(STATUS_FLAGS[0])} && FLAG_WRITE == 9'h000)
        else $error("set byte below value wrong");

    set_less_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        accept && INSN_OPC0 == 8'h0f && INSN_OPC1 == 8'h9c && reg_fld == 3'h0
        |=> SET_BYTE_DATA == {7'h00, $past(STATUS_FLAGS[4]) ^ $past(STATUS_FLAGS[8])})
        else $error("set byte less value wrong");

    full_imm_size_a: assert property (
        @(posedge MCLK) disable iff (RST || !CE)
        accept && INSN_OPC0 == 8'h81 && reg_fld == 3'h3
        |=> ISSUE_IMM_BYTES == ($past(OPSIZE32) ? 3'h4 : 3'h2) && ISSUE_WIDE)
        else $error("full immediate size wrong");
endmodule // srd_decoder
`default_nettype wire

// ===== verif/srd_fetch_model.sv
`default_nettype none
// ****************************************
// Fetch stage model
// ****************************************
module srd_fetch_model (
    input wire logic MCLK,
    input wire logic insn_ready,
    output logic insn_valid,
    output logic [7:0] insn_opc0,
    output logic [7:0] insn_opc1,
    output logic [7:0] insn_modrm,
    output logic hung
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        insn_valid = 1'b0;
        insn_opc0 = 8'h00;
        insn_opc1 = 8'h00;
        insn_modrm = 8'h00;
        hung = 1'b0;
    end
    // Offer at a falling edge, hold until taken while ready
    task automatic send(input logic [15:0] opc, input logic [7:0] modrm);
        int n;
        n = 0;
        insn_valid = 1'b1;
        {insn_opc0, insn_opc1} = opc;
        insn_modrm = modrm;
        while (insn_ready !== 1'b1 && n < 64) begin
            @(negedge MCLK);
            n++;
        end
        if (n == 64) hung = 1'b1;
        @(negedge MCLK);
    endtask
    // Released bytes no longer show the last value
    task automatic idle();
        insn_valid = 1'b0;
        insn_opc0 = ~insn_opc0;
        insn_opc1 = ~insn_opc1;
        insn_modrm = ~insn_modrm;
    endtask
endmodule // srd_fetch_model
`default_nettype wire

// ===== verif/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] opc;
        logic [7:0] modrm;
        logic [8:0] fl;
        srd_pkg::srd_op_t op;
        logic [5:0] cyc;
        logic [2:0] imm;
        logic [7:0] sb;
        logic [8:0] fw;
    } srd_row_t;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic os32 = 1'b1;
    logic [8:0] flags = 9'h000;
    logic iv, ready, ivalid, wide, ill, hung;
    logic [7:0] b0, b1, mr, sb;
    logic [5:0] cyc;
    logic [2:0] imm, seg;
    logic [8:0] fw, fu;
    srd_pkg::srd_op_t op;
    srd_pkg::srd_cnt_t cnt;
    int err_count = 0;
    int n_tests = 0;
    srd_row_t rows[] = '{
        '{16'hd000, 8'h00, 9'h000, srd_pkg::OP_ROTATE_LEFT, 6'h01, 3'h0, 8'h00, 9'h101},
        '{16'hd300, 8'h08, 9'h000, srd_pkg::OP_ROTATE_RIGHT, 6'h02, 3'h0, 8'h00, 9'h001},
        '{16'hc100, 8'h00, 9'h000, srd_pkg::OP_ROTATE_LEFT, 6'h01, 3'h1, 8'h00, 9'h001},
        '{16'hd100, 8'h20, 9'h000, srd_pkg::OP_SHIFT_LEFT_ARITH, 6'h01, 3'h0, 8'h00, 9'h11b},
        '{16'hd200, 8'h20, 9'h000, srd_pkg::OP_SHIFT_LEFT_ARITH, 6'h02, 3'h0, 8'h00, 9'h01b},
        '{16'hc000, 8'h38, 9'h000, srd_pkg::OP_SHIFT_RIGHT_ARITH, 6'h01, 3'h1, 8'h00, 9'h01b},
        '{16'h0f79, 8'h10, 9'h000, srd_pkg::OP_RESTORE_SEG_AND_DESC, 6'h06, 3'h0, 8'h00, 9'h000},
        '{16'h0f7b, 8'h00, 9'h000, srd_pkg::OP_RESTORE_LOCAL_TABLE_REG, 6'h06, 3'h0, 8'h00, 9'h000},
        '{16'h0f7d, 8'h00, 9'h000, srd_pkg::OP_RESTORE_TASK_REG_AND_DESC, 6'h06, 3'h0, 8'h00, 9'h000},
        '{16'h0faa, 8'h00, 9'h000, srd_pkg::OP_LEAVE_SYSTEM_MGMT_MODE, 6'h28, 3'h0, 8'h00, 9'h1ff},
        '{16'h9e00, 8'h00, 9'h000, srd_pkg::OP_FLAGS_FROM_ACC_HIGH, 6'h01, 3'h0, 8'h00, 9'h01f},
        '{16'h1800, 8'hc0, 9'h000, srd_pkg::OP_SUBTRACT_WITH_BORROW, 6'h01, 3'h0, 8'h00, 9'h11f},
        '{16'h8100, 8'h18, 9'h000, srd_pkg::OP_SUBTRACT_WITH_BORROW, 6'h01, 3'h4, 8'h00, 9'h11f},
        '{16'h1c00, 8'h00, 9'h000, srd_pkg::OP_SUBTRACT_WITH_BORROW, 6'h01, 3'h1, 8'h00, 9'h11f},
        '{16'h0f92, 8'h00, 9'h001, srd_pkg::OP_SET_BYTE_IF_BELOW, 6'h01, 3'h0, 8'h01, 9'h000},
        '{16'h0f96, 8'h00, 9'h008, srd_pkg::OP_SET_BYTE_IF_BELOW_OR_EQUAL, 6'h01, 3'h0, 8'h01, 9'h000},
        '{16'h0f94, 8'h00, 9'h001, srd_pkg::OP_SET_BYTE_IF_EQUAL, 6'h01, 3'h0, 8'h00, 9'h000},
        '{16'h0f9c, 8'h00, 9'h010, srd_pkg::OP_SET_BYTE_IF_LESS, 6'h01, 3'h0, 8'h01, 9'h000}
    };
    always #2.5 mclk = ~mclk;
    srd_fetch_model srd_fetch_model_i (.MCLK(mclk), .insn_ready(ready), .insn_valid(iv),
        .insn_opc0(b0), .insn_opc1(b1), .insn_modrm(mr), .hung(hung));
    srd_decoder srd_decoder_i (.MCLK(mclk), .RST(rst), .CE(ce), .INSN_VALID(iv),
        .INSN_OPC0(b0), .INSN_OPC1(b1), .INSN_MODRM(mr), .OPSIZE32(os32),
        .STATUS_FLAGS(flags), .INSN_READY(ready), .ISSUE_VALID(ivalid), .ISSUE_OP(op),
        .ISSUE_COUNT_SRC(cnt), .ISSUE_WIDE(wide), .ISSUE_CYCLES(cyc), .ISSUE_IMM_BYTES(imm),
        .ISSUE_SEG_SEL(seg), .FLAG_WRITE(fw), .FLAG_UNDEF(fu), .SET_BYTE_DATA(sb),
        .ISSUE_ILLEGAL(ill));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic issue(input logic [15:0] opc, input logic [7:0] m, input logic [8:0] fl);
        flags = fl;
        srd_fetch_model_i.send(opc, m);
        if (hung === 1'b1) begin
            err_count++;
            conclude();
        end
        chk("issue valid", 32'h1, ivalid);
    endtask
    task automatic stall(input logic [5:0] c);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 64) begin
            @(negedge mclk);
            n++;
        end
        chk("stall", c - 6'h01, n);
        if (n == 64) conclude();
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        chk("reset ready", 32'h1, ready);
        chk("reset valid", 32'h0, ivalid);
        rst = 1'b0;
        foreach (rows[i]) begin
            issue(rows[i].opc, rows[i].modrm, rows[i].fl);
            chk("op", rows[i].op, op);
            chk("cycles", rows[i].cyc, cyc);
            chk("imm bytes", rows[i].imm, imm);
            chk("wide", (rows[i].opc[15:8] == 8'h0f) ? 1'b0 : rows[i].opc[8], wide);
            chk("set byte", rows[i].sb, sb);
            chk("flag write", rows[i].fw, fw);
            stall(rows[i].cyc);
        end
        $display("test table done");
        issue(16'h0f94, 8'h00, 9'h008);
        chk("equal true", 32'h1, sb);
        issue(16'h0f9c, 8'h00, 9'h100);
        chk("less true", 32'h1, sb);
        issue(16'h0f79, 8'h28, 9'h000);
        chk("seg sel", 32'h5, seg);
        stall(6'h06);
        issue(16'h0f79, 8'h30, 9'h000);
        chk("bad seg", 32'h1, ill);
        issue(16'h0f92, 8'h08, 9'h000);
        chk("bad reg", 32'h1, ill);
        issue(16'hd200, 8'h00, 9'h000);
        chk("count reg", srd_pkg::CNT_COUNT_REGISTER_LOW, cnt);
        chk("rot undef", 32'h100, fu);
        stall(6'h02);
        issue(16'hc000, 8'h08, 9'h000);
        chk("count imm", srd_pkg::CNT_IMMEDIATE, cnt);
        issue(16'hd100, 8'h38, 9'h000);
        chk("sar one undef", 32'h004, fu);
        chk("sar one write", 32'h11b, fw);
        os32 = 1'b0;
        issue(16'h8100, 8'h18, 9'h000);
        chk("imm word", 32'h2, imm);
        issue(16'h8300, 8'h18, 9'h000);
        chk("imm sext", 32'h1, imm);
        $display("test awkward done");
        srd_fetch_model_i.idle();
        @(negedge mclk);
        ce = 1'b0;
        srd_fetch_model_i.send(16'hd000, 8'h00);
        repeat (3) @(negedge mclk);
        chk("frozen", 32'h0, ivalid);
        ce = 1'b1;
        issue(16'h0faa, 8'h00, 9'h000);
        repeat (5) @(negedge mclk);
        chk("mid stall", 32'h0, ready);
        rst = 1'b1;
        srd_fetch_model_i.idle();
        @(negedge mclk);
        chk("rerst ready", 32'h1, ready);
        chk("rerst valid", 32'h0, ivalid);
        rst = 1'b0;
        issue(16'h9e00, 8'h00, 9'h000);
        chk("after reset", srd_pkg::OP_FLAGS_FROM_ACC_HIGH, op);
        $display("test control done");
        conclude();
    end
endmodule // tb_top
`default_nettype wire
